/* bench/tb_utxc_top.sv */
// Self-checking testbench for the transmit control block
`timescale 1ns/1ps
module tb_utxc_top;
    import utxc_pkg::*;
    localparam int BD = 8;
    localparam logic [31:0] TXEN = 32'h0000_0400;
    localparam logic [31:0] RXEN = 32'h0000_1000;
    localparam logic [31:0] BRK  = 32'h0000_0800;
    localparam logic [31:0] INV  = 32'h0000_2000;
    localparam logic [31:0] ON   = 32'h0000_8000;
    localparam logic [7:0]  ST   = UTXC_OFS_STATUS_CONTROL;
    typedef struct {
        logic [1:0]  mode;
        logic [31:0] irq_full;
        logic [31:0] irq_empty;
    } utxc_row_t;
    utxc_row_t rows [4] = '{'{2'h0, 32'h0, 32'h1}, '{2'h1, 32'h0, 32'h1},
                            '{2'h2, 32'h0, 32'h1}, '{2'h0, 32'h0, 32'h1}};
    logic        sys_clk;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        tx_out;
    logic        tx_oe;
    logic        rx_pin;
    logic        rx_owned;
    logic        rx_line;
    logic        rx_char_valid;
    logic [8:0]  rx_char;
    logic        addr_match;
    logic        tx_irq;
    logic [7:0]  rx_byte;
    int          frame_len;
    int          frames;
    logic [31:0] rdv;
    int          miscompares = 0;
    int          n_compared = 0;

    utxc_top #(.BAUD_DIV(BD), .FIFO_DEPTH(32)) utxc_top_i (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .serial_tx_pin_out(tx_out),
        .serial_tx_pin_oe(tx_oe), .serial_rx_pin(rx_pin), .rx_owned(rx_owned),
        .rx_line(rx_line), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .addr_match(addr_match), .tx_irq(tx_irq));
    utxc_remote #(.BAUD_DIV(BD)) utxc_remote_i (
        .sys_clk(sys_clk), .tx_line(tx_out), .tx_oe(tx_oe), .rx_pin(rx_pin),
        .rx_byte(rx_byte), .frame_len(frame_len), .frames(frames));

    always #2.5 sys_clk = ~sys_clk;
    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
    endtask
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_frames(input int n);
        int k;
        k = 0;
        while (frames < n && k < 400) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 400) begin
            miscompares++;
            $display("MISMATCH %0t frame wait timed out", $time);
        end
        settle;
    endtask
    task automatic rxc(input logic [8:0] c, input logic [31:0] exp);
        @(posedge sys_clk);
        rx_char_valid <= 1'b1;
        rx_char       <= c;
        @(posedge sys_clk);
        rx_char_valid <= 1'b0;
        #1 chk(32'(addr_match), exp);
    endtask
    task automatic mode_rows(input bit full);
        foreach (rows[k]) begin
            wr(ST, TXEN | RXEN | (32'(rows[k].mode) << 14));
            settle;
            chk(32'(tx_irq), full ? rows[k].irq_full : rows[k].irq_empty);
        end
    endtask
    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rx_char_valid = 1'b0;
        rx_char = 9'h000;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(ST);
        chk(rdv & 32'hffff_feff, 32'h0);
        rd(8'h40);
        chk(rdv, 32'h0);
        wr(UTXC_OFS_MODE, ON);
        wr(ST, TXEN | RXEN);
        settle;
        chk(32'({tx_oe, tx_out, rx_owned, rx_line}), 32'hf);
        wr(ST, TXEN | RXEN | 32'h0000_4000);
        wr(UTXC_OFS_TX_DATA, 32'h0000_00a5);
        rd(ST);
        chk(rdv & 32'h100, 32'h0);
        chk(32'(tx_irq), 32'h0);
        settle;
        settle;
        chk(32'({tx_out, rx_line}), 32'h0);
        wait_frames(1);
        chk({16'h0, rx_byte, frame_len[7:0]}, 32'ha50a);
        rd(ST);
        chk(rdv & 32'h100, 32'h100);
        chk(32'(tx_irq), 32'h1);
        wr(ST, TXEN | RXEN | BRK);
        wait_frames(2);
        chk({16'h0, rx_byte, frame_len[7:0]}, 32'h000e);
        rd(ST);
        chk(rdv & BRK, 32'h0);
        @(posedge sys_clk);
        reg_addr <= UTXC_OFS_TX_DATA;
        reg_wr   <= 1'b1;
        for (int i = 0; i < 34; i++) begin
            reg_wdata <= 32'(i);
            @(posedge sys_clk);
        end
        reg_wr <= 1'b0;
        rd(ST);
        chk(rdv & 32'h300, 32'h200);
        mode_rows(1'b1);
        wr(ST, RXEN);
        settle;
        chk(32'(tx_oe), 32'h0);
        rd(ST);
        chk(rdv & 32'h300, 32'h100);
        mode_rows(1'b0);
        wr(ST, TXEN | RXEN | INV);
        settle;
        chk(32'(tx_out), 32'h0);
        wr(UTXC_OFS_MODE, ON | 32'h0000_1000);
        settle;
        chk(32'(tx_out), 32'h1);
        wr(ST, TXEN | RXEN);
        settle;
        chk(32'(tx_out), 32'h0);
        wr(UTXC_OFS_MODE, ON);
        wr(ST, 32'h015a_1400);
        rxc(9'h15a, 32'h1);
        rxc(9'h15b, 32'h0);
        rxc(9'h05a, 32'h0);
        wr(ST, 32'h005a_1400);
        rxc(9'h15a, 32'h0);
        wr(ST, 32'h015a_0400);
        settle;
        chk(32'({rx_owned, rx_line}), 32'h1);
        rxc(9'h15a, 32'h0);
        end_sim;
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        miscompares++;
        end_sim;
    end
endmodule

/* bench/utxc_remote.sv */
// Remote serial device model: decodes frames and loops the line back
`timescale 1ns/1ps
module utxc_remote #(
    parameter int BAUD_DIV = 8
) (
    // Clock
    input  wire logic  sys_clk,
    // Line from the block
    input  wire logic  tx_line,
    input  wire logic  tx_oe,
    output logic       rx_pin,
    // Last decoded frame
    output logic [7:0] rx_byte,
    output int         frame_len,
    output int         frames
);
    logic [15:0] bits;
    int          i;
    // Pull-up holds the line high once the block lets go
    assign rx_pin = tx_oe ? tx_line : 1'b1;
    initial begin
        frames    = 0;
        frame_len = 0;
        rx_byte   = 8'h00;
    end
    // Mid-bit sampling; a low stop slot means the low run goes on
    always begin
        @(negedge tx_line iff tx_oe);
        repeat (BAUD_DIV / 2) @(posedge sys_clk);
        bits = 16'h0000;
        i    = 0;
        while (i < 15 && !(i >= 9 && bits[i])) begin
            i = i + 1;
            repeat (BAUD_DIV) @(posedge sys_clk);
            bits[i] = tx_line;
        end
        rx_byte   = bits[8:1];
        frame_len = i + 1;
        frames    = frames + 1;
    end
endmodule

/* src/utxc_pkg.sv */
// Constants for the serial port transmit control and address detect block
package utxc_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] UTXC_OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] UTXC_OFS_MODE           = 8'h04;
    localparam logic [7:0] UTXC_OFS_TX_DATA        = 8'h08;
    localparam logic [31:0] UTXC_STATUS_RESET      = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Status and control fields
    // ----------------------------------------------------------------
    localparam int UTXC_ADM_BIT    = 24;
    localparam int UTXC_ADDR_LSB   = 16;
    localparam int UTXC_ADDR_MSB   = 23;
    localparam int UTXC_TXISEL_LSB = 14;
    localparam int UTXC_TXISEL_MSB = 15;
    localparam int UTXC_INV_BIT    = 13;
    localparam int UTXC_RXEN_BIT   = 12;
    localparam int UTXC_BRK_BIT    = 11;
    localparam int UTXC_TXEN_BIT   = 10;
    localparam int UTXC_FULL_BIT   = 9;
    localparam int UTXC_EMPTY_BIT  = 8;

    // ----------------------------------------------------------------
    // Mode register fields
    // ----------------------------------------------------------------
    localparam int UTXC_ON_BIT = 15;
    localparam int UTXC_IR_BIT = 12;

    // ----------------------------------------------------------------
    // Transmit interrupt select codes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        UTXC_IRQ_NOT_FULL  = 2'h0,
        UTXC_IRQ_ALL_DONE  = 2'h1,
        UTXC_IRQ_BUF_EMPTY = 2'h2,
        UTXC_IRQ_RESERVED  = 2'h3
    } utxc_irq_mode_t;

    // ----------------------------------------------------------------
    // Frame shapes and timing
    // ----------------------------------------------------------------
    localparam int UTXC_FRAME_W       = 14;
    localparam logic [3:0] UTXC_DATA_BITS  = 4'ha;
    localparam logic [3:0] UTXC_BRK_BITS   = 4'he;
    localparam int UTXC_BRK_ZEROS     = 12;
    localparam int UTXC_DEF_BAUD_DIV  = 16;
    localparam int UTXC_IR_PULSE_NUM  = 3;
    localparam int UTXC_IR_PULSE_DEN  = 16;

    typedef enum logic [1:0] {
        UTXC_ST_IDLE  = 2'b01,
        UTXC_ST_SHIFT = 2'b10
    } utxc_state_t;
endpackage

/* src/utxc_top.sv */
// Serial port transmit control, break, tx interrupt select, rx enable, address detect
//
// Behaviour
// - Address-detect mode runs only while enable bit 24 is set.
// - Address field bits 23-16 is the character matched in address-detect mode.
// - Select 00: tx interrupt while buffer has a free entry.
// - Select 01: tx interrupt once all characters fully shifted out.
// - Select 10: tx interrupt while transmit buffer is empty.
// - Infrared off: tx pin idles low if inverted, high otherwise.
// - Infrared on: encoded tx pin idles high if inverted, low otherwise.
// - Receiver enable with module on takes the rx pin, else ignored.
// - Send-break makes next transmission start bit, twelve zeros, stop bit.
// - Hardware clears send-break when the break sequence finishes.
// - Transmit enable with module on drives the tx pin.
// - Clearing transmit enable aborts shifting, empties buffer, releases pin.
// - Buffer-full flag bit 9 reads 1 only when buffer is full.
// - All-empty flag bit 8 reads 1 only when shifter and buffer empty.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Transmit buffer
// ----------------------------------------------------------------
module utxc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != FULL_CNT);
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
module utxc_top
    import utxc_pkg::*;
#(
    parameter int BAUD_DIV = UTXC_DEF_BAUD_DIV,
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Serial pins
    output logic             serial_tx_pin_out,
    output logic             serial_tx_pin_oe,
    input  wire logic        serial_rx_pin,
    // Receive path
    output logic             rx_owned,
    output logic             rx_line,
    input  wire logic        rx_char_valid,
    input  wire logic [8:0]  rx_char,
    output logic             addr_match,
    // Transmit interrupt level
    output logic             tx_irq
);
    import utxc_pkg::*;

    localparam int CNT_W = $clog2(BAUD_DIV);
    localparam logic [CNT_W-1:0] BAUD_LAST = CNT_W'(BAUD_DIV - 1);
    // Infrared pulse is a fixed fraction of a bit period, at least a cycle
    localparam int IR_CYC_I = (BAUD_DIV * UTXC_IR_PULSE_NUM) / UTXC_IR_PULSE_DEN;
    localparam logic [CNT_W-1:0] IR_CYC = CNT_W'((IR_CYC_I < 1) ? 1 : IR_CYC_I);

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic           addr_detect_enable_reg;
    logic [7:0]     addr_char_reg;
    utxc_irq_mode_t tx_irq_mode_select_reg;
    logic           tx_idle_invert_reg;
    logic           receiver_enable_reg;
    logic           send_break_reg;
    logic           transmitter_enable_reg;
    logic           module_on_reg;
    logic           infrared_encode_enable_reg;
    logic           wr_status;
    logic           wr_mode;
    logic           wr_data;
    logic           tx_active;
    logic           break_done;

    assign wr_status = reg_wr && (reg_addr == UTXC_OFS_STATUS_CONTROL);
    assign wr_mode   = reg_wr && (reg_addr == UTXC_OFS_MODE);
    assign wr_data   = reg_wr && (reg_addr == UTXC_OFS_TX_DATA);
    assign tx_active = transmitter_enable_reg && module_on_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            addr_detect_enable_reg <= 1'b0;
            addr_char_reg          <= 8'h00;
            tx_irq_mode_select_reg <= UTXC_IRQ_NOT_FULL;
            tx_idle_invert_reg     <= 1'b0;
            receiver_enable_reg    <= 1'b0;
            transmitter_enable_reg <= 1'b0;
        end else if (wr_status) begin
            addr_detect_enable_reg <= reg_wdata[UTXC_ADM_BIT];
            addr_char_reg          <= reg_wdata[UTXC_ADDR_MSB:UTXC_ADDR_LSB];
            tx_irq_mode_select_reg <= utxc_irq_mode_t'(reg_wdata[UTXC_TXISEL_MSB:UTXC_TXISEL_LSB]);
            tx_idle_invert_reg     <= reg_wdata[UTXC_INV_BIT];
            receiver_enable_reg    <= reg_wdata[UTXC_RXEN_BIT];
            transmitter_enable_reg <= reg_wdata[UTXC_TXEN_BIT];
        end
    end

    // A software write in the clearing cycle wins, so a fresh request survives
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            send_break_reg <= 1'b0;
        end else if (wr_status) begin
            send_break_reg <= reg_wdata[UTXC_BRK_BIT];
        end else if (break_done) begin
            send_break_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            module_on_reg              <= 1'b0;
            infrared_encode_enable_reg <= 1'b0;
        end else if (wr_mode) begin
            module_on_reg              <= reg_wdata[UTXC_ON_BIT];
            infrared_encode_enable_reg <= reg_wdata[UTXC_IR_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Transmit buffer and shifter
    // ----------------------------------------------------------------
    utxc_state_t                state_reg;
    logic [UTXC_FRAME_W-1:0]    frame_reg;
    logic [3:0]                 bits_left_reg;
    logic [CNT_W-1:0]           baud_cnt_reg;
    logic                       break_frame_reg;
    logic                       fifo_in_ready;
    logic                       fifo_out_valid;
    logic [7:0]                 fifo_out_data;
    logic                       take_char;
    logic                       start_break;
    logic                       bit_end;
    logic                       tx_buffer_full;
    logic                       tx_all_empty;

    assign start_break  = (state_reg == UTXC_ST_IDLE) && tx_active && send_break_reg;
    assign take_char    = (state_reg == UTXC_ST_IDLE) && tx_active && !send_break_reg
                          && fifo_out_valid;
    assign bit_end      = (state_reg == UTXC_ST_SHIFT) && (baud_cnt_reg == BAUD_LAST);
    assign break_done   = bit_end && (bits_left_reg == 4'h1) && break_frame_reg;
    assign tx_buffer_full = !fifo_in_ready;
    assign tx_all_empty = (state_reg == UTXC_ST_IDLE) && !fifo_out_valid;

    // A write to a full buffer is dropped; software polls the full flag
    utxc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .flush     (!tx_active),
        .in_valid  (wr_data),
        .in_ready  (fifo_in_ready),
        .in_data   (reg_wdata[7:0]),
        .out_valid (fifo_out_valid),
        .out_ready (take_char),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge sys_clk) begin
        if (!resetn || !tx_active) begin
            state_reg       <= UTXC_ST_IDLE;
            frame_reg       <= '1;
            bits_left_reg   <= 4'h0;
            baud_cnt_reg    <= '0;
            break_frame_reg <= 1'b0;
        end else begin
            case (state_reg)
                UTXC_ST_IDLE: begin
                    baud_cnt_reg <= '0;
                    if (start_break) begin
                        // Start bit and twelve zeros, then the stop bit
                        frame_reg       <= {1'b1, {UTXC_BRK_ZEROS{1'b0}}, 1'b0};
                        bits_left_reg   <= UTXC_BRK_BITS;
                        break_frame_reg <= 1'b1;
                        state_reg       <= UTXC_ST_SHIFT;
                    end else if (take_char) begin
                        frame_reg       <= {4'hf, 1'b1, fifo_out_data, 1'b0};
                        bits_left_reg   <= UTXC_DATA_BITS;
                        break_frame_reg <= 1'b0;
                        state_reg       <= UTXC_ST_SHIFT;
                    end
                end
                UTXC_ST_SHIFT: begin
                    baud_cnt_reg <= bit_end ? '0 : baud_cnt_reg + 1'b1;
                    if (bit_end) begin
                        frame_reg     <= {1'b1, frame_reg[UTXC_FRAME_W-1:1]};
                        bits_left_reg <= bits_left_reg - 4'h1;
                        if (bits_left_reg == 4'h1) begin
                            state_reg <= UTXC_ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= UTXC_ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Transmit pin
    // ----------------------------------------------------------------
    logic line_bit;
    logic ir_pulse;

    assign line_bit = (state_reg == UTXC_ST_SHIFT) ? frame_reg[0] : 1'b1;
    assign ir_pulse = !line_bit && (baud_cnt_reg < IR_CYC);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            serial_tx_pin_out <= 1'b1;
            serial_tx_pin_oe  <= 1'b0;
        end else begin
            serial_tx_pin_oe <= tx_active;
            if (infrared_encode_enable_reg) begin
                serial_tx_pin_out <= ir_pulse ^ tx_idle_invert_reg;
            end else begin
                serial_tx_pin_out <= line_bit ^ tx_idle_invert_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive pin and address detect
    // ----------------------------------------------------------------
    logic rx_sync1_reg;
    logic rx_sync2_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rx_sync1_reg <= 1'b1;
            rx_sync2_reg <= 1'b1;
        end else begin
            rx_sync1_reg <= serial_rx_pin;
            rx_sync2_reg <= rx_sync1_reg;
        end
    end

    // Released line reads idle so the receive path sees no activity
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rx_owned <= 1'b0;
            rx_line  <= 1'b1;
        end else begin
            rx_owned <= receiver_enable_reg && module_on_reg;
            rx_line  <= (receiver_enable_reg && module_on_reg) ? rx_sync2_reg : 1'b1;
        end
    end

    // Bit 8 of a received character marks it as an address
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            addr_match <= 1'b0;
        end else begin
            addr_match <= rx_char_valid && addr_detect_enable_reg && rx_owned
                          && rx_char[8] && (rx_char[7:0] == addr_char_reg);
        end
    end

    // ----------------------------------------------------------------
    // Interrupt level and read data
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_irq <= 1'b0;
        end else begin
            case (tx_irq_mode_select_reg)
                UTXC_IRQ_NOT_FULL:  tx_irq <= !tx_buffer_full;
                UTXC_IRQ_ALL_DONE:  tx_irq <= tx_all_empty;
                UTXC_IRQ_BUF_EMPTY: tx_irq <= !fifo_out_valid;
                default:            tx_irq <= 1'b0;
            endcase
        end
    end

    logic [31:0] status_word;

    always_comb begin
        status_word = UTXC_STATUS_RESET;
        status_word[UTXC_ADM_BIT]                   = addr_detect_enable_reg;
        status_word[UTXC_ADDR_MSB:UTXC_ADDR_LSB]     = addr_char_reg;
        status_word[UTXC_TXISEL_MSB:UTXC_TXISEL_LSB] = tx_irq_mode_select_reg;
        status_word[UTXC_INV_BIT]                   = tx_idle_invert_reg;
        status_word[UTXC_RXEN_BIT]                  = receiver_enable_reg;
        status_word[UTXC_BRK_BIT]                   = send_break_reg;
        status_word[UTXC_TXEN_BIT]                  = transmitter_enable_reg;
        status_word[UTXC_FULL_BIT]                  = tx_buffer_full;
        status_word[UTXC_EMPTY_BIT]                 = tx_all_empty;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            case (reg_addr)
                UTXC_OFS_STATUS_CONTROL: reg_rdata <= status_word;
                UTXC_OFS_MODE: begin
                    reg_rdata <= 32'h0000_0000;
                    reg_rdata[UTXC_ON_BIT] <= module_on_reg;
                    reg_rdata[UTXC_IR_BIT] <= infrared_encode_enable_reg;
                end
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    localparam int AST_BRK_MAX = 14 * BAUD_DIV + 2;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_break_start;
        start_break && !wr_status;
    endsequence

    sequence s_idle_plain;
        (state_reg == UTXC_ST_IDLE) && !infrared_encode_enable_reg && $stable(tx_idle_invert_reg);
    endsequence

    AST_ADM_OFF: assert property ((rx_char_valid && !addr_detect_enable_reg) |=> !addr_match)
        else $error("address match while detect disabled");
    AST_ADM_HIT: assert property ((rx_char_valid && addr_detect_enable_reg && rx_owned
        && rx_char[8] && rx_char[7:0] == addr_char_reg) |=> addr_match)
        else $error("matching address character missed");
    AST_IRQ_FREE: assert property ((tx_irq_mode_select_reg == UTXC_IRQ_NOT_FULL)
        |=> tx_irq == !$past(tx_buffer_full))
        else $error("tx interrupt wrong in free-entry mode");
    AST_IRQ_DONE: assert property ((tx_irq_mode_select_reg == UTXC_IRQ_ALL_DONE)
        |=> tx_irq == $past(tx_all_empty))
        else $error("tx interrupt wrong in all-done mode");
    AST_IRQ_EMPTY: assert property ((tx_irq_mode_select_reg == UTXC_IRQ_BUF_EMPTY
        && fifo_out_valid) |=> !tx_irq)
        else $error("tx interrupt with queued data in empty mode");
    AST_IDLE_PLAIN: assert property (s_idle_plain ##1 s_idle_plain
        |-> serial_tx_pin_out == !tx_idle_invert_reg)
        else $error("tx pin idle level wrong");
    AST_IDLE_IR: assert property (((state_reg == UTXC_ST_IDLE) && infrared_encode_enable_reg)[*2]
        |-> serial_tx_pin_out == $past(tx_idle_invert_reg))
        else $error("encoded tx pin idle level wrong");
    AST_RX_OWN: assert property (1'b1 |=> rx_owned == $past(receiver_enable_reg && module_on_reg))
        else $error("rx pin ownership wrong");
    AST_BREAK_END: assert property (s_break_start |=> send_break_reg ##[1:AST_BRK_MAX] !send_break_reg)
        else $error("break never completed");
    AST_ABORT: assert property (!tx_active |=> (state_reg == UTXC_ST_IDLE) && !fifo_out_valid
        && !serial_tx_pin_oe)
        else $error("disable did not abort transmitter");
    AST_TX_ALL_EMPTY: assert property ((reg_rd && reg_addr == UTXC_OFS_STATUS_CONTROL
        && (state_reg == UTXC_ST_SHIFT || fifo_out_valid)) |=> !reg_rdata[UTXC_EMPTY_BIT])
        else $error("all-empty read as set while busy");
endmodule
